//--- shared/fault_protect_pkg.sv
package fault_protect_pkg;
   // Number of half bridges
   localparam int unsigned NUM_PHASES = 3;
   // Mode select encoding
   localparam logic MODE_CYCLE_LIMIT = 1'b0;
   localparam logic MODE_LATCHED     = 1'b1;
   // Reset values
   localparam logic [2:0] LATCH_RESET    = 3'h0;
   localparam logic [2:0] BLANK_RESET    = 3'h0;
   localparam logic       THERMAL_RESET  = 1'b0;
   localparam logic [2:0] ARMED_RESET    = 3'h0;
   // Short detect: overcurrent persisting this long while limiting latches
   localparam int unsigned SHORT_TIME_NS    = 250;
   localparam int unsigned CLK_PERIOD_NS    = 10;
   localparam int unsigned SHORT_CYCLES     =
      (SHORT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SHORT_CNT_W      = 5;
   localparam logic [SHORT_CNT_W-1:0] SHORT_LIMIT =
      SHORT_CNT_W'(SHORT_CYCLES);
   // Gate command encoding per bridge
   typedef enum logic [1:0] {
      BRIDGE_HIZ,
      BRIDGE_PWM,
      BRIDGE_LOW_ON,
      BRIDGE_ALL_OFF
   } bridge_cmd_t;
endpackage

//--- hw/half_bridge_ctrl.sv
`timescale 1ns/1ns
module half_bridge_ctrl (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic mode_latched,
   input  wire logic pwm_sync,
   input  wire logic pwm_rise,
   input  wire logic reset_rise,
   input  wire logic reset_low,
   input  wire logic oc_high,
   input  wire logic oc_low,
   input  wire logic global_off,
   input  wire logic oc_clear,
   output logic      gate_high,
   output logic      gate_low,
   output logic      hiz,
   output logic      oc_latched
);
   logic                                       blank_hs_q;
   logic                                       blank_ls_q;
   logic [fault_protect_pkg::SHORT_CNT_W-1:0]  short_cnt_q;
   logic                                       trip_now;
   logic                                       in_limit;

   assign in_limit = blank_hs_q | blank_ls_q;
   assign trip_now = oc_high | oc_low;

   always_ff @(posedge clk) begin
      if (!resetn || oc_clear) begin
         blank_ls_q <= 1'b0;
      end else if (mode_latched || reset_low || oc_latched) begin
         blank_ls_q <= 1'b0;
      end else if (oc_low) begin
         blank_ls_q <= 1'b1;
      end else if (pwm_rise) begin
         blank_ls_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn || oc_clear) begin
         blank_hs_q <= 1'b0;
      end else if (mode_latched || reset_low || oc_latched) begin
         blank_hs_q <= 1'b0;
      end else if (oc_high) begin
         blank_hs_q <= 1'b1;
      end else if (pwm_rise) begin
         blank_hs_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn || oc_clear) begin
         short_cnt_q <= '0;
      end else if (trip_now && in_limit && !mode_latched) begin
         if (short_cnt_q != fault_protect_pkg::SHORT_LIMIT) begin
            short_cnt_q <= short_cnt_q + 1'b1;
         end
      end else begin
         short_cnt_q <= '0;
      end
   end

   // Latched shutdown; a trip in the reset edge cycle still wins
   always_ff @(posedge clk) begin
      if (!resetn || oc_clear) begin
         oc_latched <= 1'b0;
      end else if (mode_latched && trip_now && !reset_low) begin
         oc_latched <= 1'b1;
      end else if (short_cnt_q == fault_protect_pkg::SHORT_LIMIT) begin
         oc_latched <= 1'b1;
      end else if (reset_rise) begin
         oc_latched <= 1'b0;
      end
   end

   // Gate outputs; oc_latched is registered so mode_latched trips
   // combinationally gate the bridge off in the same cycle
   always_comb begin
      gate_high = 1'b0;
      gate_low  = 1'b0;
      hiz       = 1'b1;
      if (global_off || reset_low || oc_latched ||
          (mode_latched && trip_now)) begin
         hiz = 1'b1;
      end else if (blank_hs_q || oc_high) begin
         hiz      = 1'b0;
         gate_low = 1'b1;
      end else if (blank_ls_q || oc_low) begin
         hiz = 1'b0;
      end else begin
         hiz       = 1'b0;
         gate_high = pwm_sync;
         gate_low  = ~pwm_sync;
      end
   end
endmodule

//--- hw/half_bridge_fault_protection.sv
// Overview of operation
// - Mode input picks cycle limit or latch
// - Independent high and low detectors per bridge
// - Low-side trip blanks both FETs
// - High-side trip turns low FET on
// - Persisting short latches bridge Hi-Z
// - Latched mode shuts bridge at once
// - Warning low above warning temperature
// - Thermal shutdown latches, all Hi-Z, fault
// - Thermal latch clears after all resets rise
// - Power-on holds off until supplies good
// - Undervoltage: all Hi-Z and fault low
// - Undervoltage recovers without latching
// - Reset low forces bridge Hi-Z
// - Reset rise clears bridge overcurrent latch
// - Fault and warning outputs active low
`timescale 1ns/1ns
module half_bridge_fault_protection (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       mode_select,
   input  wire logic [2:0] pwm_in,
   input  wire logic [2:0] phase_reset_n,
   input  wire logic [2:0] oc_high_det,
   input  wire logic [2:0] oc_low_det,
   input  wire logic       temp_warn_det,
   input  wire logic       temp_shutdown_det,
   input  wire logic       gate_supply_ok,
   input  wire logic       logic_supply_ok,
   output logic [2:0]      gate_high,
   output logic [2:0]      gate_low,
   output logic [2:0]      bridge_hiz,
   output logic            fault_n_o,
   output logic            fault_n_oe,
   output logic            overtemp_warning_n_o,
   output logic            overtemp_warning_n_oe
);
   localparam int unsigned N = fault_protect_pkg::NUM_PHASES;
   localparam int unsigned NIN = 4 * N + 5;
   // Reset pins sync to their idle high level so no false rise follows
   localparam logic [NIN-1:0] SYNC_IDLE =
      {{N{1'b0}}, {N{1'b1}}, {(2 * N + 5){1'b0}}};

   logic [NIN-1:0] meta_q;
   logic [NIN-1:0] sync_q;
   logic [N-1:0]   pwm_s;
   logic [N-1:0]   rst_n_s;
   logic [N-1:0]   ohs_s;
   logic [N-1:0]   ols_s;
   logic           mode_s;
   logic           warn_s;
   logic           tsd_s;
   logic           gsup_s;
   logic           lsup_s;
   logic [N-1:0]   pwm_prev_q;
   logic [N-1:0]   rst_prev_q;
   logic [N-1:0]   pwm_rise;
   logic [N-1:0]   rst_rise;
   logic           thermal_shutdown;
   logic [N-1:0]   armed_q;
   logic           power_good;
   logic           por_q;
   logic           undervolt;
   logic           global_off;
   logic [N-1:0]   oc_latched;
   logic           warn_q;
   logic           fault_q;

   // Pins are asynchronous; two stages before anything looks at them
   always_ff @(posedge clk) begin
      if (!resetn) begin
         meta_q <= SYNC_IDLE;
         sync_q <= SYNC_IDLE;
      end else begin
         meta_q <= {pwm_in, phase_reset_n, oc_high_det, oc_low_det,
                    mode_select, temp_warn_det, temp_shutdown_det,
                    gate_supply_ok, logic_supply_ok};
         sync_q <= meta_q;
      end
   end

   assign {pwm_s, rst_n_s, ohs_s, ols_s, mode_s, warn_s, tsd_s,
           gsup_s, lsup_s} = sync_q;

   // Edge history; reset inputs start high so no false rise follows reset
   always_ff @(posedge clk) begin
      if (!resetn) begin
         pwm_prev_q <= '0;
         rst_prev_q <= '1;
      end else begin
         pwm_prev_q <= pwm_s;
         rst_prev_q <= rst_n_s;
      end
   end

   assign pwm_rise = pwm_s & ~pwm_prev_q;
   assign rst_rise = rst_n_s & ~rst_prev_q;

   assign power_good = gsup_s & lsup_s;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         por_q <= 1'b1;
      end else begin
         por_q <= ~power_good;
      end
   end

   assign undervolt = ~power_good;

   // Needs a rise on every reset
   always_ff @(posedge clk) begin
      if (!resetn) begin
         thermal_shutdown <= fault_protect_pkg::THERMAL_RESET;
         armed_q          <= fault_protect_pkg::ARMED_RESET;
      end else if (tsd_s) begin
         thermal_shutdown <= 1'b1;
         armed_q          <= '0;
      end else if (thermal_shutdown) begin
         if ((armed_q | rst_rise) == {N{1'b1}}) begin
            thermal_shutdown <= 1'b0;
            armed_q          <= '0;
         end else begin
            armed_q <= armed_q | rst_rise;
         end
      end
   end

   assign global_off = undervolt | thermal_shutdown;

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_bridge
         half_bridge_ctrl u_ctrl (
            .clk          (clk),
            .resetn       (resetn),
            .mode_latched (mode_s == fault_protect_pkg::MODE_LATCHED),
            .pwm_sync     (pwm_s[g]),
            .pwm_rise     (pwm_rise[g]),
            .reset_rise   (rst_rise[g]),
            .reset_low    (~rst_n_s[g]),
            .oc_high      (ohs_s[g]),
            .oc_low       (ols_s[g]),
            .global_off   (global_off),
            .oc_clear     (por_q),
            .gate_high    (gate_high[g]),
            .gate_low     (gate_low[g]),
            .hiz          (bridge_hiz[g]),
            .oc_latched   (oc_latched[g])
         );
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (!resetn) begin
         warn_q  <= 1'b0;
         fault_q <= 1'b0;
      end else begin
         warn_q  <= warn_s;
         fault_q <= global_off | (|oc_latched);
      end
   end

   // Open drain: only ever pull low, pullup is outside
   assign fault_n_o             = 1'b0;
   assign fault_n_oe            = fault_q;
   assign overtemp_warning_n_o  = 1'b0;
   assign overtemp_warning_n_oe = warn_q;
endmodule

//--- bench/half_bridge_fault_protection_sva.sv
`timescale 1ns/1ns
module fault_protect_sva (
   input wire logic       clk,
   input wire logic       resetn,
   input wire logic       mode_select,
   input wire logic [2:0] phase_reset_n,
   input wire logic [2:0] oc_high_det,
   input wire logic [2:0] oc_low_det,
   input wire logic       temp_warn_det,
   input wire logic       temp_shutdown_det,
   input wire logic       gate_supply_ok,
   input wire logic       logic_supply_ok,
   input wire logic [2:0] gate_high,
   input wire logic [2:0] gate_low,
   input wire logic [2:0] bridge_hiz,
   input wire logic       fault_n_oe,
   input wire logic       overtemp_warning_n_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence trip_s;
      mode_select && phase_reset_n[0] && oc_high_det[0];
   endsequence
   sequence calm_s;
      &phase_reset_n && gate_supply_ok && logic_supply_ok;
   endsequence
   uv_shut_a: assert property ((!gate_supply_ok) [*4] |->
      &bridge_hiz && fault_n_oe) else $error("no uv shutdown");
   rst_hiz_a: assert property ((!phase_reset_n[0]) [*3] |->
      bridge_hiz[0] && !gate_high[0] && !gate_low[0]) else $error("no hiz");
   lat_shut_a: assert property (trip_s [*5] |->
      bridge_hiz[0] && fault_n_oe) else $error("no oc shutdown");
   cbc_low_a: assert property (
      (!mode_select && phase_reset_n[0] && oc_low_det[0]) [*3]
      |-> !gate_high[0] && !gate_low[0]) else $error("low trip open");
   cbc_high_a: assert property (
      (!mode_select && phase_reset_n[0] && oc_high_det[0]) [*3]
      ##0 !bridge_hiz[0] |-> gate_low[0] && !gate_high[0])
      else $error("high trip wrong");
   therm_a: assert property (temp_shutdown_det [*5] |->
      &bridge_hiz && fault_n_oe) else $error("no thermal shutdown");
   warn_lvl_a: assert property ($stable(temp_warn_det) [*5] |->
      overtemp_warning_n_oe == temp_warn_det) else $error("warning wrong");
   latch_hold_a: assert property (calm_s [*8] ##0 fault_n_oe |=>
      fault_n_oe) else $error("fault dropped early");
endmodule
bind half_bridge_fault_protection fault_protect_sva fault_protect_sva_i (
   .clk, .resetn, .mode_select, .phase_reset_n, .oc_high_det, .oc_low_det,
   .temp_warn_det, .temp_shutdown_det, .gate_supply_ok, .logic_supply_ok,
   .gate_high, .gate_low, .bridge_hiz, .fault_n_oe, .overtemp_warning_n_oe);

//--- bench/pwm_ctrl_model.sv
`timescale 1ns/1ns
module pwm_ctrl_model (
   input  wire logic       clk,
   output logic [2:0]      pwm
);
   logic [5:0] cnt_q = 6'h00;
   initial pwm = 3'h0;
   // Same level on all three phases, low pulse each period
   // Long period so a short trip fits in one high phase
   always @(negedge clk) begin
      cnt_q <= cnt_q + 6'h01;
      pwm   <= {3{cnt_q < 6'h36}};
   end
endmodule

//--- bench/half_bridge_fault_protection_test.sv
`timescale 1ns/1ns
module half_bridge_fault_protection_test;
   logic       clk = 1'b0, resetn = 1'b0, mode_select = 1'b0;
   logic [2:0] phase_reset_n = 3'h7, oc_high_det = 3'h0, oc_low_det = 3'h0;
   logic       temp_warn_det = 1'b0, temp_shutdown_det = 1'b0;
   logic       gate_supply_ok = 1'b1, logic_supply_ok = 1'b1;
   logic [2:0] pwm_in, gate_high, gate_low, bridge_hiz, flg;
   logic       fault_n_o, fault_n_oe;
   logic       overtemp_warning_n_o, overtemp_warning_n_oe;
   int         n_fail = 0, num_checks = 0, cyc = 0;
   assign flg = {fault_n_oe, overtemp_warning_n_oe,
                 fault_n_o | overtemp_warning_n_o};
   always #5 clk = ~clk;
   pwm_ctrl_model pwm_ctrl_model_i (.clk, .pwm(pwm_in));
   half_bridge_fault_protection half_bridge_fault_protection_i (
      .clk, .resetn, .mode_select, .pwm_in, .phase_reset_n, .oc_high_det,
      .oc_low_det, .temp_warn_det, .temp_shutdown_det, .gate_supply_ok,
      .logic_supply_ok, .gate_high, .gate_low, .bridge_hiz, .fault_n_o,
      .fault_n_oe, .overtemp_warning_n_o, .overtemp_warning_n_oe);
   function automatic logic [2:0] st(input int i);
      return {gate_high[i], gate_low[i], bridge_hiz[i]};
   endfunction
   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic check(input logic [2:0] seen, input logic [2:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      if (n_fail == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic next_cycle();
      @(posedge pwm_in[0]);
      step(4);
   endtask
   task automatic pulse(input int i);
      phase_reset_n[i] = 1'b0;
      step(4);
      check(st(i), 3'h1);
      phase_reset_n[i] = 1'b1;
      step(6);
   endtask
   task automatic t_uv(input logic [1:0] sel);
      {gate_supply_ok, logic_supply_ok} = sel;
      step(5);
      check(bridge_hiz, 3'h7);
      check(flg, 3'h4);
      {gate_supply_ok, logic_supply_ok} = 2'h3;
      step(6);
      check(bridge_hiz, 3'h0);
      check(flg, 3'h0);
   endtask
   task automatic t_cbc();
      next_cycle();
      check(st(0), 3'h4);
      oc_low_det[0] = 1'b1;
      step(3);
      oc_low_det[0] = 1'b0;
      check(st(0), 3'h0);
      step(4);
      check(st(0), 3'h0);
      check(st(1), 3'h4);
      next_cycle();
      check(st(0), 3'h4);
      oc_high_det[0] = 1'b1;
      step(3);
      oc_high_det[0] = 1'b0;
      step(4);
      check(st(0), 3'h2);
      next_cycle();
      check(st(0), 3'h4);
      oc_low_det[0] = 1'b1;
      step(fault_protect_pkg::SHORT_CYCLES + 8);
      oc_low_det[0] = 1'b0;
      check(st(0), 3'h1);
      check(flg, 3'h4);
      pulse(0);
      check(flg, 3'h0);
   endtask
   task automatic t_lat();
      mode_select = 1'b1;
      step(4);
      oc_high_det[0] = 1'b1;
      step(6);
      check(st(0), 3'h1);
      check(flg, 3'h4);
      oc_high_det[0] = 1'b0;
      step(10);
      check(flg, 3'h4);
      pulse(0);
      check(flg, 3'h0);
      mode_select = 1'b0;
   endtask
   task automatic t_therm();
      temp_warn_det = 1'b1;
      step(5);
      check(flg, 3'h2);
      temp_shutdown_det = 1'b1;
      step(6);
      temp_shutdown_det = 1'b0;
      temp_warn_det = 1'b0;
      check(bridge_hiz, 3'h7);
      check(flg, 3'h6);
      for (int i = 0; i < 3; i++) begin
         pulse(i);
         check(flg, (i < 2) ? 3'h4 : 3'h0);
      end
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         conclude();
      end
   end
   initial begin
      step(5);
      check(bridge_hiz, 3'h7);
      resetn = 1'b1;
      step(8);
      t_uv(2'h1);
      t_uv(2'h2);
      t_cbc();
      t_lat();
      t_therm();
      conclude();
   end
endmodule
